// ---- sblp_edge_mem.sv ----
// Previous-scan state store, one bit per edge-detecting primitive slot.
`timescale 1ns/1ps
module sblp_edge_mem #(
  parameter int unsigned SLOTS = sblp_pkg::EDGE_SLOTS_DEF,
  parameter int unsigned IDX_W = $clog2(SLOTS)
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // Read port
  input  wire logic [IDX_W-1:0] rd_idx,
  output logic                  rd_val,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_idx,
  input  wire logic             wr_val
);

  logic [SLOTS-1:0] mem_q;

  // A slot index too narrow for the store would leave upper slots unreachable.
  if (SLOTS < 2 || (1 << IDX_W) < SLOTS)
  begin : g_bad_slots
    $error("sblp_edge_mem: SLOTS must be at least 2 and fit IDX_W.");
  end

  // Kept as flops so reset can clear every slot in one edge; a RAM would need a clear walk.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      mem_q <= {SLOTS{sblp_pkg::RST_BIT}};
    end
    else if (wr_en)
    begin
      mem_q[wr_idx] <= wr_val;
    end
  end

  // The read returns the state left by the previous scan, before this cycle's write lands.
  assign rd_val = mem_q[rd_idx];

  AST_SLOT_UPDATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_en |=> mem_q[$past(wr_idx)] == $past(wr_val))
    else $error("Edge slot did not take the sampled value.");

  AST_SLOT_CLEAR: assert property (@(posedge clk_sys)
    !rstn |=> mem_q == '0)
    else $error("Edge slots not cleared by reset.");

endmodule

// ---- sblp_pkg.sv ----
// Shared constants and types for the scan bit logic primitive evaluator.
package sblp_pkg;

  // Default number of edge-detecting primitive slots in one program.
  localparam int unsigned EDGE_SLOTS_DEF = 2048;

  // Reset value of every stored bit and every output flag.
  localparam logic RST_BIT = 1'b0;

  // Width of the primitive selector.
  localparam int unsigned OP_W = 4;

  // Primitive selector.
  typedef enum logic [OP_W-1:0] {
    OP_COIL,
    OP_FORCED_COIL,
    OP_INVERTER,
    OP_INVERT_COIL,
    OP_POS_PULSE_CONTACT,
    OP_NEG_PULSE_CONTACT,
    OP_POS_PULSE_COIL,
    OP_NEG_PULSE_COIL
  } sblp_op_t;

endpackage

// ---- sblp_tb.sv ----
// Self-checking testbench for the scan bit primitive evaluator.
`timescale 1ns/1ps
module testbench;
  localparam int unsigned SLOTS = 16;
  localparam int unsigned IW    = $clog2(SLOTS);

  logic               clk_sys;
  logic               rstn;
  logic               eval_valid;
  sblp_pkg::sblp_op_t eval_op;
  logic               rung_in;
  logic               dev_bit;
  logic [IW-1:0]      edge_idx;
  logic               tool_wr;
  logic               tool_val;
  logic               res_valid_q;
  logic               rung_out_q;
  logic               dev_wr_en_q;
  logic               dev_wr_val_q;
  logic               force_wr_en_q;
  logic               force_wr_val_q;
  logic [3:0]         exp_nx;
  logic [3:0]         exp_q;
  logic [1:0]         fexp_nx;
  logic [1:0]         fexp_q;
  int                 num_errors = 0;
  int                 n_checks   = 0;
  int                 cycles     = 0;

  sblp_top #(.EDGE_SLOTS(SLOTS)) dut_u (
    .clk_sys        (clk_sys),
    .rstn           (rstn),
    .eval_valid     (eval_valid),
    .eval_op        (eval_op),
    .rung_in        (rung_in),
    .dev_bit        (dev_bit),
    .edge_idx       (edge_idx),
    .tool_wr        (tool_wr),
    .tool_val       (tool_val),
    .res_valid_q    (res_valid_q),
    .rung_out_q     (rung_out_q),
    .dev_wr_en_q    (dev_wr_en_q),
    .dev_wr_val_q   (dev_wr_val_q),
    .force_wr_en_q  (force_wr_en_q),
    .force_wr_val_q (force_wr_val_q)
  );

  always #12.5 clk_sys = ~clk_sys;

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(string name, logic [3:0] seen, logic [3:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // Expectations travel with the request and are judged half a cycle after the taking edge,
  // so back-to-back requests need no gap between them.
  always @(posedge clk_sys)
  begin
    exp_q  <= exp_nx;
    fexp_q <= fexp_nx;
    cycles <= cycles + 1;
    if (cycles >= 1000)
    begin
      num_errors = num_errors + 1;
      summarize();
    end
  end

  always @(negedge clk_sys)
  begin
    if (rstn === 1'b1)
    begin
      check("result", {res_valid_q, rung_out_q, dev_wr_en_q, dev_wr_val_q}, exp_q);
      check("force", {2'h0, force_wr_en_q, force_wr_val_q}, {2'h0, fexp_q});
    end
  end

  // Expected result is {valid, rung out, write enable, write value}; rd is {rung, device}.
  task automatic ev(sblp_pkg::sblp_op_t op, logic [1:0] rd, logic [IW-1:0] idx, logic [3:0] e);
    eval_valid <= 1'b1;
    eval_op    <= op;
    rung_in    <= rd[1];
    dev_bit    <= rd[0];
    edge_idx   <= idx;
    exp_nx     <= e;
    @(posedge clk_sys);
  endtask

  task automatic idle();
    eval_valid <= 1'b0;
    exp_nx     <= 4'h0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic t_ops();
    ev(sblp_pkg::OP_COIL, 2'h2, 4'h0, 4'hF);
    ev(sblp_pkg::OP_COIL, 2'h0, 4'h0, 4'hA);
    ev(sblp_pkg::OP_INVERT_COIL, 2'h0, 4'h0, 4'hB);
    ev(sblp_pkg::OP_INVERT_COIL, 2'h2, 4'h0, 4'hE);
    ev(sblp_pkg::OP_INVERTER, 2'h0, 4'h0, 4'hC);
    ev(sblp_pkg::OP_INVERTER, 2'h2, 4'h0, 4'h8);
    ev(sblp_pkg::OP_FORCED_COIL, 2'h2, 4'h0, 4'hC);
    ev(sblp_pkg::OP_FORCED_COIL, 2'h0, 4'h0, 4'h8);
    idle();
  endtask

  task automatic t_pcont();
    ev(sblp_pkg::OP_POS_PULSE_CONTACT, 2'h3, 4'h3, 4'hC);
    ev(sblp_pkg::OP_POS_PULSE_CONTACT, 2'h3, 4'h3, 4'h8);
    ev(sblp_pkg::OP_POS_PULSE_CONTACT, 2'h2, 4'h3, 4'h8);
    ev(sblp_pkg::OP_POS_PULSE_CONTACT, 2'h1, 4'h3, 4'h8);
    ev(sblp_pkg::OP_POS_PULSE_CONTACT, 2'h3, 4'h3, 4'h8);
    idle();
  endtask

  task automatic t_ncont();
    ev(sblp_pkg::OP_NEG_PULSE_CONTACT, 2'h2, 4'h4, 4'h8);
    ev(sblp_pkg::OP_NEG_PULSE_CONTACT, 2'h3, 4'h4, 4'h8);
    ev(sblp_pkg::OP_NEG_PULSE_CONTACT, 2'h2, 4'h4, 4'hC);
    ev(sblp_pkg::OP_NEG_PULSE_CONTACT, 2'h2, 4'h4, 4'h8);
    ev(sblp_pkg::OP_NEG_PULSE_CONTACT, 2'h1, 4'h4, 4'h8);
    ev(sblp_pkg::OP_NEG_PULSE_CONTACT, 2'h0, 4'h4, 4'h8);
    ev(sblp_pkg::OP_NEG_PULSE_CONTACT, 2'h1, 4'h4, 4'h8);
    ev(sblp_pkg::OP_NEG_PULSE_CONTACT, 2'h2, 4'h4, 4'hC);
    ev(sblp_pkg::OP_NEG_PULSE_CONTACT, 2'h2, 4'h4, 4'h8);
    idle();
  endtask

  task automatic t_coils();
    ev(sblp_pkg::OP_POS_PULSE_COIL, 2'h2, 4'h5, 4'hF);
    ev(sblp_pkg::OP_POS_PULSE_COIL, 2'h2, 4'h5, 4'hE);
    ev(sblp_pkg::OP_POS_PULSE_COIL, 2'h0, 4'h5, 4'hA);
    ev(sblp_pkg::OP_POS_PULSE_COIL, 2'h2, 4'h5, 4'hF);
    ev(sblp_pkg::OP_NEG_PULSE_COIL, 2'h2, 4'h6, 4'hE);
    ev(sblp_pkg::OP_NEG_PULSE_COIL, 2'h0, 4'h6, 4'hB);
    ev(sblp_pkg::OP_NEG_PULSE_COIL, 2'h0, 4'h6, 4'hA);
    idle();
  endtask

  // Highest and lowest slots interleaved, then a refused selector that must not touch a slot.
  task automatic t_slots();
    ev(sblp_pkg::OP_POS_PULSE_COIL, 2'h2, 4'hF, 4'hF);
    ev(sblp_pkg::OP_POS_PULSE_COIL, 2'h2, 4'h0, 4'hF);
    ev(sblp_pkg::OP_POS_PULSE_COIL, 2'h2, 4'hF, 4'hE);
    ev(sblp_pkg::OP_POS_PULSE_COIL, 2'h0, 4'h0, 4'hA);
    ev(sblp_pkg::OP_POS_PULSE_COIL, 2'h2, 4'h7, 4'hF);
    ev(sblp_pkg::sblp_op_t'(4'hF), 2'h0, 4'h7, 4'h0);
    ev(sblp_pkg::OP_POS_PULSE_COIL, 2'h2, 4'h7, 4'hE);
    idle();
  endtask

  task automatic t_tool();
    tool_wr  <= 1'h1;
    tool_val <= 1'h0;
    fexp_nx  <= 2'h2;
    ev(sblp_pkg::OP_FORCED_COIL, 2'h2, 4'h0, 4'hC);
    tool_val <= 1'h1;
    fexp_nx  <= 2'h3;
    ev(sblp_pkg::OP_FORCED_COIL, 2'h0, 4'h0, 4'h8);
    tool_wr  <= 1'h0;
    fexp_nx  <= 2'h1;
    idle();
    ev(sblp_pkg::OP_FORCED_COIL, 2'h2, 4'h0, 4'hC);
    idle();
  endtask

  // Slot 5 was left set; a second reset must clear it.
  task automatic t_reset();
    rstn    <= 1'b0;
    fexp_nx <= 2'h0;
    repeat (2) @(posedge clk_sys);
    rstn    <= 1'b1;
    ev(sblp_pkg::OP_POS_PULSE_COIL, 2'h2, 4'h5, 4'hF);
    idle();
  endtask

  initial
  begin
    clk_sys    = 1'b0;
    rstn       = 1'b0;
    eval_valid = 1'b0;
    eval_op    = sblp_pkg::OP_COIL;
    rung_in    = 1'b0;
    dev_bit    = 1'b0;
    edge_idx   = 4'h0;
    tool_wr    = 1'b0;
    tool_val   = 1'b0;
    exp_nx     = 4'h0;
    fexp_nx    = 2'h0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    t_ops();
    t_pcont();
    t_ncont();
    t_coils();
    t_slots();
    t_tool();
    t_reset();
    summarize();
  end
endmodule

// ---- sblp_top.sv ----
// Per-scan evaluator for forced, inverting and pulse bit primitives.
`timescale 1ns/1ps
// Notes on behaviour
// - Forced coil never writes its device bit; rung input only passes to rung output.
// - Programming tool may force the held bit ON or OFF; value is kept.
// - Inverter rung output is the complement of its rung input.
// - Invert coil writes the complement of the rung input to its bit.
// - Positive pulse contact: ON when input ON and device rose since last scan.
// - Negative pulse contact: ON when input ON and device fell since last scan.
// - Positive pulse coil sets its bit ON one scan on input rise, else OFF.
// - Negative pulse coil sets its bit ON one scan on input fall, else OFF.
// - Plain coil copies the rung input into its device bit.
module sblp_top #(
  parameter int unsigned EDGE_SLOTS = sblp_pkg::EDGE_SLOTS_DEF,
  parameter int unsigned IDX_W      = $clog2(EDGE_SLOTS)
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // Primitive evaluation request
  input  wire logic                eval_valid,
  input  wire sblp_pkg::sblp_op_t  eval_op,
  input  wire logic                rung_in,
  input  wire logic                dev_bit,
  input  wire logic [IDX_W-1:0]    edge_idx,
  // Programming tool override of a forced coil bit
  input  wire logic                tool_wr,
  input  wire logic                tool_val,
  // Evaluation result
  output logic                     res_valid_q,
  output logic                     rung_out_q,
  output logic                     dev_wr_en_q,
  output logic                     dev_wr_val_q,
  // Forced bit write toward the device image
  output logic                     force_wr_en_q,
  output logic                     force_wr_val_q
);

  // Refused at elaboration so a bad slot count never reaches simulation or synthesis.
  if (EDGE_SLOTS < 2 || (1 << IDX_W) < EDGE_SLOTS)
  begin : g_bad_slots
    $error("sblp_top: EDGE_SLOTS must be at least 2 and fit IDX_W.");
  end

  logic prev_bit;
  logic edge_wr;
  logic edge_sample;
  logic rung_out_d;
  logic dev_wr_en_d;
  logic dev_wr_val_d;
  logic legal_op;

  function automatic logic is_edge_op(input sblp_pkg::sblp_op_t op);
    is_edge_op = (op == sblp_pkg::OP_POS_PULSE_CONTACT) ||
                 (op == sblp_pkg::OP_NEG_PULSE_CONTACT) ||
                 (op == sblp_pkg::OP_POS_PULSE_COIL)    ||
                 (op == sblp_pkg::OP_NEG_PULSE_COIL);
  endfunction

  function automatic logic is_contact_op(input sblp_pkg::sblp_op_t op);
    is_contact_op = (op == sblp_pkg::OP_POS_PULSE_CONTACT) ||
                    (op == sblp_pkg::OP_NEG_PULSE_CONTACT);
  endfunction

  // Slot count limit is the program's duty; the store simply has that many slots.
  sblp_edge_mem #(
    .SLOTS (EDGE_SLOTS),
    .IDX_W (IDX_W)
  ) u_edge_mem (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .rd_idx  (edge_idx),
    .rd_val  (prev_bit),
    .wr_en   (edge_wr),
    .wr_idx  (edge_idx),
    .wr_val  (edge_sample)
  );

  // Contacts track the device bit, pulse coils track the rung input.
  assign edge_wr     = eval_valid && is_edge_op(eval_op);
  assign edge_sample = is_contact_op(eval_op) ? dev_bit : rung_in;

  always_comb
  begin
    rung_out_d   = sblp_pkg::RST_BIT;
    dev_wr_en_d  = sblp_pkg::RST_BIT;
    dev_wr_val_d = sblp_pkg::RST_BIT;
    legal_op     = 1'b1;
    unique case (eval_op)
      sblp_pkg::OP_COIL:
      begin
        dev_wr_en_d  = 1'b1;
        dev_wr_val_d = rung_in;
        rung_out_d   = rung_in;
      end
      sblp_pkg::OP_FORCED_COIL:
      begin
        dev_wr_en_d = 1'b0;
        rung_out_d  = rung_in;
      end
      sblp_pkg::OP_INVERTER:
      begin
        rung_out_d = !rung_in;
      end
      sblp_pkg::OP_INVERT_COIL:
      begin
        dev_wr_en_d  = 1'b1;
        dev_wr_val_d = !rung_in;
        rung_out_d   = rung_in;
      end
      sblp_pkg::OP_POS_PULSE_CONTACT:
      begin
        rung_out_d = rung_in && dev_bit && !prev_bit;
      end
      sblp_pkg::OP_NEG_PULSE_CONTACT:
      begin
        rung_out_d = rung_in && !dev_bit && prev_bit;
      end
      sblp_pkg::OP_POS_PULSE_COIL:
      begin
        dev_wr_en_d  = 1'b1;
        dev_wr_val_d = rung_in && !prev_bit;
        rung_out_d   = rung_in;
      end
      sblp_pkg::OP_NEG_PULSE_COIL:
      begin
        dev_wr_en_d  = 1'b1;
        dev_wr_val_d = !rung_in && prev_bit;
        rung_out_d   = rung_in;
      end
      default:
      begin
        legal_op = 1'b0;
      end
    endcase
  end

  // Result registers; an unknown selector gives no result and no write.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      res_valid_q  <= sblp_pkg::RST_BIT;
      rung_out_q   <= sblp_pkg::RST_BIT;
      dev_wr_en_q  <= sblp_pkg::RST_BIT;
      dev_wr_val_q <= sblp_pkg::RST_BIT;
    end
    else
    begin
      res_valid_q  <= eval_valid && legal_op;
      rung_out_q   <= eval_valid && legal_op && rung_out_d;
      dev_wr_en_q  <= eval_valid && legal_op && dev_wr_en_d;
      dev_wr_val_q <= eval_valid && legal_op && dev_wr_val_d;
    end
  end

  // Tool override runs on its own path so a scan in progress cannot lose it.
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      force_wr_en_q  <= sblp_pkg::RST_BIT;
      force_wr_val_q <= sblp_pkg::RST_BIT;
    end
    else
    begin
      force_wr_en_q  <= tool_wr;
      force_wr_val_q <= tool_wr ? tool_val : force_wr_val_q;
    end
  end

  AST_FORCED_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!rstn)
    eval_valid && eval_op == sblp_pkg::OP_FORCED_COIL |=> res_valid_q && !dev_wr_en_q)
    else $error("Forced coil wrote its device bit.");

  AST_TOOL_FORCE: assert property (@(posedge clk_sys) disable iff (!rstn)
    tool_wr |=> force_wr_en_q && force_wr_val_q == $past(tool_val))
    else $error("Tool force value not delivered.");

  AST_TOOL_HOLD: assert property (@(posedge clk_sys) disable iff (!rstn)
    !tool_wr |=> !force_wr_en_q && $stable(force_wr_val_q))
    else $error("Forced value changed without a tool write.");

  AST_INVERTER: assert property (@(posedge clk_sys) disable iff (!rstn)
    eval_valid && eval_op == sblp_pkg::OP_INVERTER
    |=> rung_out_q == !$past(rung_in) && !dev_wr_en_q)
    else $error("Inverter output is not the complement.");

  AST_INVERT_COIL: assert property (@(posedge clk_sys) disable iff (!rstn)
    eval_valid && eval_op == sblp_pkg::OP_INVERT_COIL
    |=> dev_wr_en_q && dev_wr_val_q == !$past(rung_in))
    else $error("Invert coil wrote the wrong value.");

  AST_POS_CONTACT: assert property (@(posedge clk_sys) disable iff (!rstn)
    eval_valid && eval_op == sblp_pkg::OP_POS_PULSE_CONTACT
    |=> rung_out_q == ($past(rung_in) && $past(dev_bit) && !$past(prev_bit)))
    else $error("Positive pulse contact output wrong.");

  AST_NEG_CONTACT: assert property (@(posedge clk_sys) disable iff (!rstn)
    eval_valid && eval_op == sblp_pkg::OP_NEG_PULSE_CONTACT
    |=> rung_out_q == ($past(rung_in) && !$past(dev_bit) && $past(prev_bit)))
    else $error("Negative pulse contact output wrong.");

  AST_POS_COIL: assert property (@(posedge clk_sys) disable iff (!rstn)
    eval_valid && eval_op == sblp_pkg::OP_POS_PULSE_COIL
    |=> dev_wr_en_q && dev_wr_val_q == ($past(rung_in) && !$past(prev_bit)))
    else $error("Positive pulse coil wrote the wrong value.");

  AST_NEG_COIL: assert property (@(posedge clk_sys) disable iff (!rstn)
    eval_valid && eval_op == sblp_pkg::OP_NEG_PULSE_COIL
    |=> dev_wr_en_q && dev_wr_val_q == (!$past(rung_in) && $past(prev_bit)))
    else $error("Negative pulse coil wrote the wrong value.");

  AST_COIL: assert property (@(posedge clk_sys) disable iff (!rstn)
    eval_valid && eval_op == sblp_pkg::OP_COIL
    |=> dev_wr_en_q && dev_wr_val_q == $past(rung_in))
    else $error("Coil did not copy its input.");

  AST_EDGE_STORE: assert property (@(posedge clk_sys) disable iff (!rstn)
    eval_valid && eval_op == sblp_pkg::OP_POS_PULSE_COIL ##1
    eval_valid && eval_op == sblp_pkg::OP_POS_PULSE_COIL && edge_idx == $past(edge_idx)
    |-> prev_bit == $past(rung_in))
    else $error("Edge slot did not keep the last sample.");

  AST_IDLE_QUIET: assert property (@(posedge clk_sys) disable iff (!rstn)
    !eval_valid |=> !res_valid_q && !dev_wr_en_q && !rung_out_q)
    else $error("Result produced without a request.");

endmodule
